// ### shared/crfs_pkg.sv
// Purpose: Shared constants and types of the core regulator supervisor
// Assumes: 100 MHz system clock, comparator results arrive as digital levels
// Notes: Times are kept in their own unit, cycle counts are derived
package crfs_pkg;
  // Clock and switching period
  localparam int CLK_PERIOD_NS = 10;
  localparam int SW_PERIOD_NS = 1000; // 1 MHz per phase by default
  localparam int SW_PERIOD_CYC = SW_PERIOD_NS / CLK_PERIOD_NS;
  // Power-good release delay in switching periods
  localparam int PG_DELAY_PERIODS = 3072;
  // Fault windows in phase clock cycles
  localparam int UV_WINDOW = 32;
  localparam int OC_WINDOW = 32;
  // Mask held after each mode change, or code change while running, in phase cycles
  localparam int MASK_PERIODS = 32;
  localparam int CODE_W = 6;
  localparam int CNT_W = 6;
  // APB map, byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CODE = 8'h08;
  localparam logic [7:0] ADDR_COUNT = 8'h0C;
  // Control register fields and reset value
  localparam int CTRL_RUN_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  // Status register fields
  localparam int ST_STATE_LSB = 0;
  localparam int ST_MODE_LSB = 4;
  localparam int ST_OV_BIT = 8;
  localparam int ST_UV_BIT = 9;
  localparam int ST_OC_BIT = 10;
  localparam int ST_PGOK_BIT = 11;
  localparam int ST_MASK_BIT = 12;

  typedef enum logic [1:0] {
    CRFS_ACTIVE = 2'b00,
    CRFS_DEEP = 2'b01,
    CRFS_DEEPER = 2'b10
  } crfs_mode_t;

  typedef enum logic [2:0] {
    CRFS_IDLE = 3'b000,
    CRFS_BOOT = 3'b001,
    CRFS_WAIT_REL = 3'b010,
    CRFS_TIMING = 3'b011,
    CRFS_RUN = 3'b100,
    CRFS_OFF = 3'b101
  } crfs_state_t;
endpackage : crfs_pkg

// ### core/crfs_phase_pwm.sv
// Purpose: One phase modulator, sawtooth ramp compared with error level
// Assumes: Error level scaled to ramp counts, one ramp per switching period
// Notes: Start offset lets two instances run interleaved
`timescale 1ns/1ns
`default_nettype none
module crfs_phase_pwm #(
  parameter int PERIOD = 100,
  parameter int OFFSET = 0,
  parameter int W = 7
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] error_level_in,
  output logic pwm_out,
  output logic wrap_out
);
  localparam logic [W-1:0] LAST = W'(PERIOD - 1);
  localparam logic [W-1:0] START = W'(OFFSET);
  logic [W-1:0] ramp_r;

  // Sawtooth ramp, restarts each switching period
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ramp_r <= START;
    end else if (ramp_r == LAST) begin
      ramp_r <= '0;
    end else begin
      ramp_r <= ramp_r + 1'b1;
    end
  end

  // Higher error gives a longer on time
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pwm_out <= 1'b0;
      wrap_out <= 1'b0;
    end else begin
      pwm_out <= (ramp_r < error_level_in);
      wrap_out <= (ramp_r == LAST);
    end
  end
endmodule : crfs_phase_pwm
`default_nettype wire

// ### core/crfs_supervisor.sv
// Purpose: Power-good handshake, fault latches and phase drive of a buck
// Assumes: Comparator results and release-current detect are digital levels
// Notes: Registers reached over APB; outputs all come from flip-flops
`timescale 1ns/1ns
`default_nettype none
module crfs_supervisor
  import crfs_pkg::*;
#(
  parameter int PG_DELAY = PG_DELAY_PERIODS,
  parameter int PERIOD = SW_PERIOD_CYC,
  parameter int RAMP_W = 7
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic enable_in,
  input wire logic boot_reached_in,
  input wire logic power_ok_line_in,
  output logic power_ok_line_out,
  output logic power_ok_line_oe_out,
  input wire logic [CODE_W-1:0] cpu_voltage_code_in,
  input wire logic stop_request_n_in,
  input wire logic deeper_request_in,
  input wire logic ov_above_in,
  input wire logic ov_below_release_in,
  input wire logic uv_below_in,
  input wire logic oc_avg_over_in,
  input wire logic [RAMP_W-1:0] error_level_in,
  output logic [CODE_W-1:0] active_code_out,
  output logic [1:0] setpoint_select_out,
  output logic [1:0] high_side_on_out,
  output logic [1:0] low_side_on_out,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  localparam int PGC_W = $clog2(PG_DELAY + 1);
  localparam logic [PGC_W-1:0] PG_LAST = PGC_W'(PG_DELAY - 1);
  localparam logic [CNT_W-1:0] UV_LAST = CNT_W'(UV_WINDOW);
  localparam logic [CNT_W-1:0] OC_LAST = CNT_W'(OC_WINDOW);
  localparam logic [CNT_W-1:0] MASK_LOAD = CNT_W'(MASK_PERIODS);

  crfs_state_t state_r, state_nxt;
  crfs_mode_t mode_r, mode_nxt;
  logic [31:0] ctrl_r;
  logic [CODE_W-1:0] code_r, code_seen_r;
  logic [PGC_W-1:0] pg_cnt_r;
  logic [CNT_W-1:0] uv_cnt_r, oc_cnt_r, mask_cnt_r;
  logic ov_latch_r, ov_pull_r, uv_latch_r, oc_latch_r;
  logic enable_d_r, pg_ok_r;
  logic [1:0] pwm_raw, wrap_raw;
  logic phase_tick, shutdown, en_toggle, changed;
  logic apb_access, apb_done;

  // Ramps half a period apart keep the phases interleaved
  crfs_phase_pwm #(.PERIOD(PERIOD), .OFFSET(0), .W(RAMP_W)) u_phase0 (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .error_level_in(error_level_in),
    .pwm_out(pwm_raw[0]),
    .wrap_out(wrap_raw[0])
  );
  crfs_phase_pwm #(.PERIOD(PERIOD), .OFFSET(PERIOD / 2), .W(RAMP_W))
    u_phase1 (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .error_level_in(error_level_in),
    .pwm_out(pwm_raw[1]),
    .wrap_out(wrap_raw[1])
  );

  // Phase clock: one tick per switching period of phase 0
  assign phase_tick = wrap_raw[0];
  assign shutdown = ov_latch_r | uv_latch_r | oc_latch_r;
  assign en_toggle = enable_d_r & ~enable_in;

  // Sleep input decode, deeper wins over stop
  always_comb begin
    if (deeper_request_in) begin
      mode_nxt = CRFS_DEEPER;
    end else if (stop_request_n_in) begin
      mode_nxt = CRFS_ACTIVE;
    end else begin
      mode_nxt = CRFS_DEEP;
    end
  end

  // Mode and enable history
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_r <= CRFS_ACTIVE;
      enable_d_r <= 1'b0;
      code_seen_r <= '0;
    end else begin
      mode_r <= mode_nxt;
      enable_d_r <= enable_in;
      code_seen_r <= cpu_voltage_code_in;
    end
  end

  assign changed = (mode_nxt != mode_r) ||
                   (state_r == CRFS_RUN && code_seen_r != cpu_voltage_code_in);

  // Start-up sequence
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      CRFS_IDLE: begin
        if (enable_in && ctrl_r[CTRL_RUN_BIT]) begin
          state_nxt = CRFS_BOOT;
        end
      end
      CRFS_BOOT: begin
        if (boot_reached_in) begin
          state_nxt = CRFS_WAIT_REL;
        end
      end
      CRFS_WAIT_REL: begin
        if (power_ok_line_in) begin
          state_nxt = CRFS_TIMING;
        end
      end
      CRFS_TIMING: begin
        if (phase_tick && pg_cnt_r == PG_LAST) begin
          state_nxt = CRFS_RUN;
        end
      end
      CRFS_RUN: state_nxt = CRFS_RUN;
      CRFS_OFF: state_nxt = CRFS_OFF;
      default: state_nxt = CRFS_IDLE;
    endcase
    if (shutdown) begin
      state_nxt = CRFS_OFF;
    end
    if (!enable_in || !ctrl_r[CTRL_RUN_BIT]) begin
      state_nxt = ov_latch_r ? CRFS_OFF : CRFS_IDLE;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= CRFS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Code captured at release detect, then followed in active running
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      code_r <= '0;
    end else if (state_r == CRFS_WAIT_REL && power_ok_line_in) begin
      code_r <= cpu_voltage_code_in;
    end else if (state_r == CRFS_RUN && mode_r == CRFS_ACTIVE) begin
      code_r <= cpu_voltage_code_in;
    end
  end

  // Power-good delay counted in switching periods
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pg_cnt_r <= '0;
    end else if (state_r != CRFS_TIMING) begin
      pg_cnt_r <= '0;
    end else if (phase_tick && pg_cnt_r != PG_LAST) begin
      pg_cnt_r <= pg_cnt_r + 1'b1;
    end
  end

  // Mask restarts on every change and holds power-good low while slewing; fault counters ignore it
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mask_cnt_r <= '0;
    end else if (changed) begin
      mask_cnt_r <= MASK_LOAD;
    end else if (phase_tick && mask_cnt_r != '0) begin
      mask_cnt_r <= mask_cnt_r - 1'b1;
    end
  end

  // Overvoltage latch and hysteretic pull-down; only reset clears it
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ov_latch_r <= 1'b0;
      ov_pull_r <= 1'b0;
    end else if (ov_above_in) begin
      ov_latch_r <= 1'b1;
      ov_pull_r <= 1'b1;
    end else if (ov_below_release_in) begin
      ov_pull_r <= 1'b0;
    end
  end

  // Undervoltage: trips once below for more than the window
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      uv_cnt_r <= '0;
      uv_latch_r <= 1'b0;
    end else if (!enable_in || en_toggle) begin
      uv_cnt_r <= '0;
      uv_latch_r <= 1'b0;
    end else if (state_r != CRFS_RUN || !uv_below_in) begin
      uv_cnt_r <= '0;
    end else if (phase_tick) begin
      if (uv_cnt_r == UV_LAST) begin
        uv_latch_r <= 1'b1;
      end else begin
        uv_cnt_r <= uv_cnt_r + 1'b1;
      end
    end
  end

  // Overcurrent up/down counter on the averaged current compare
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      oc_cnt_r <= '0;
      oc_latch_r <= 1'b0;
    end else if (!enable_in || en_toggle) begin
      oc_cnt_r <= '0;
      oc_latch_r <= 1'b0;
    end else if (phase_tick && state_r != CRFS_IDLE) begin
      if (oc_avg_over_in) begin
        oc_cnt_r <= oc_cnt_r + 1'b1;
        if (oc_cnt_r + 1'b1 == OC_LAST) begin
          oc_latch_r <= 1'b1;
        end
      end else if (oc_cnt_r != '0) begin
        oc_cnt_r <= oc_cnt_r - 1'b1;
      end
    end
  end

  // Power-good: released only when running, unmasked and fault-free
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pg_ok_r <= 1'b0;
    end else begin
      pg_ok_r <= (state_nxt == CRFS_RUN) && !shutdown && !changed &&
                 mask_cnt_r == '0 && !ov_above_in && !uv_below_in;
    end
  end

  // Open-drain line: pulled low except while waiting or released
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      power_ok_line_out <= 1'b0;
      power_ok_line_oe_out <= 1'b1;
    end else begin
      power_ok_line_out <= 1'b0;
      power_ok_line_oe_out <= !(state_nxt == CRFS_WAIT_REL) &&
                              !(pg_ok_r && !shutdown);
    end
  end

  // Gate drive: overvoltage pull-down beats every other state
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      high_side_on_out <= 2'b00;
      low_side_on_out <= 2'b00;
    end else if (ov_latch_r || ov_above_in) begin
      high_side_on_out <= 2'b00;
      low_side_on_out <= (ov_pull_r || ov_above_in) ? 2'b11 : 2'b00;
    end else if (shutdown || state_r == CRFS_IDLE || state_r == CRFS_OFF) begin
      high_side_on_out <= 2'b00;
      low_side_on_out <= 2'b00;
    end else begin
      high_side_on_out <= pwm_raw;
      low_side_on_out <= ~pwm_raw;
    end
  end

  // Setpoint for regulation and for both fault references
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      active_code_out <= '0;
      setpoint_select_out <= CRFS_ACTIVE;
    end else begin
      active_code_out <= code_r;
      setpoint_select_out <= mode_r;
    end
  end

  // APB slave: one wait state, answer on second access cycle
  assign apb_access = psel & penable;
  assign apb_done = apb_access & pready;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_access & ~pready;
      pslverr <= 1'b0;
      prdata <= '0;
      if (apb_access && !pready) begin
        case (paddr)
          ADDR_CTRL: prdata <= pwrite ? 32'h0000_0000 : ctrl_r;
          ADDR_STATUS: begin
            prdata <= 32'h0000_0000;
            prdata[ST_STATE_LSB +: 3] <= state_r;
            prdata[ST_MODE_LSB +: 2] <= mode_r;
            prdata[ST_OV_BIT] <= ov_latch_r;
            prdata[ST_UV_BIT] <= uv_latch_r;
            prdata[ST_OC_BIT] <= oc_latch_r;
            prdata[ST_PGOK_BIT] <= pg_ok_r;
            prdata[ST_MASK_BIT] <= (mask_cnt_r != '0);
          end
          ADDR_CODE: prdata <= {26'h0, code_r};
          ADDR_COUNT: prdata <= {18'h0, oc_cnt_r, 2'h0, uv_cnt_r};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Control register: run permit gates the whole start-up
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_r <= CTRL_RESET;
    end else if (apb_done && pwrite && paddr == ADDR_CTRL) begin
      ctrl_r <= {31'h0, pwdata[CTRL_RUN_BIT]};
    end
  end

  // Assertions
  a_ov_sets_latch: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ov_above_in |=> ov_latch_r && low_side_on_out == 2'b11)
    else $error("overvoltage did not latch and pull low");
  a_ov_latch_held: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ov_latch_r |=> ov_latch_r)
    else $error("overvoltage latch cleared without reset");
  a_ov_release_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ov_latch_r && !ov_above_in && ov_below_release_in ##1 !ov_above_in
    |=> high_side_on_out == 2'b00 && low_side_on_out == 2'b00)
    else $error("switches not off below release level");
  a_shut_no_high: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    shutdown |=> high_side_on_out == 2'b00)
    else $error("high side on during shutdown");
  a_shut_pg_low: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $past(shutdown) && shutdown |-> power_ok_line_oe_out)
    else $error("power good released during shutdown");
  a_uv_trip_count: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(uv_latch_r) |-> $past(uv_cnt_r) == UV_LAST)
    else $error("undervoltage trip at wrong count");
  a_oc_trip_count: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(oc_latch_r) |-> oc_cnt_r == OC_LAST)
    else $error("overcurrent trip at wrong count");
  a_pg_after_delay: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(pg_ok_r) |-> state_r == CRFS_RUN && mask_cnt_r == '0)
    else $error("power good before delay or during mask");
  a_mode_decode: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    deeper_request_in |=> mode_r == CRFS_DEEPER)
    else $error("deeper request not decoded");
  a_code_capture: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state_r == CRFS_WAIT_REL && power_ok_line_in && !shutdown && enable_in
    && ctrl_r[CTRL_RUN_BIT] |=> code_r == $past(cpu_voltage_code_in))
    else $error("voltage code not captured");

  c_reach_run: cover property (@(posedge clk_in) state_r == CRFS_RUN);
  c_ov_cycle: cover property (@(posedge clk_in) $fell(ov_pull_r) && ov_latch_r);
  c_uv_trip: cover property (@(posedge clk_in) $rose(uv_latch_r));
  c_oc_recover: cover property (@(posedge clk_in)
    oc_cnt_r == 6'h1 && !oc_avg_over_in && phase_tick);
endmodule : crfs_supervisor
`default_nettype wire

// ### verification/crfs_companion_model.sv
// Purpose: Companion regulators sharing the open-drain power-good line
// Assumes: Each companion lets go of the line once its own rail is ready
// Notes: Release detect is registered, like a slow current comparator
`timescale 1ns/1ns
`default_nettype none
module crfs_companion_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ready_a_in,
  input wire logic ready_b_in,
  input wire logic core_oe_in,
  output logic release_detect_out,
  output logic system_power_ok_out
);
  // Sink current flows only once both companions have let go
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      release_detect_out <= 1'b0;
    end else begin
      release_detect_out <= ready_a_in & ready_b_in;
    end
  end
  // Wired-OR of open drains, any party pulling keeps the system line low
  assign system_power_ok_out = ready_a_in & ready_b_in & !core_oe_in;
endmodule : crfs_companion_model
`default_nettype wire

// ### verification/crfs_supervisor_test.sv
// Purpose: Self-checking bench of the core regulator supervisor
// Assumes: Short power-good delay and period so the run stays brief
// Notes: Expected values come from integer models kept in the bench
`timescale 1ns/1ns
`default_nettype none
module crfs_supervisor_test import crfs_pkg::*;;
  localparam int P = 8;
  localparam int D = 4;
  logic clk_in, rst_n_in, enable_in, boot_in, rdy_a, rdy_b, det, sys_ok;
  logic stop_n, deeper, ov_above, ov_rel, uv_below, oc_over, err_s;
  logic pg_o, oe, psel, penable, pwrite, pready, pslverr;
  logic [CODE_W-1:0] code_in, act_code;
  logic [6:0] err;
  logic [1:0] sel, hs, ls;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int n_fail, samples_checked, n, m, e, exp_code;
  int cyc = 0;
  longint t0;
  crfs_supervisor #(.PG_DELAY(D), .PERIOD(P), .RAMP_W(7)) dut_u (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .enable_in(enable_in),
    .boot_reached_in(boot_in), .power_ok_line_in(det),
    .power_ok_line_out(pg_o), .power_ok_line_oe_out(oe),
    .cpu_voltage_code_in(code_in), .stop_request_n_in(stop_n),
    .deeper_request_in(deeper), .ov_above_in(ov_above),
    .ov_below_release_in(ov_rel), .uv_below_in(uv_below),
    .oc_avg_over_in(oc_over), .error_level_in(err),
    .active_code_out(act_code), .setpoint_select_out(sel),
    .high_side_on_out(hs), .low_side_on_out(ls), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  crfs_companion_model pm_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .ready_a_in(rdy_a), .ready_b_in(rdy_b), .core_oe_in(oe),
    .release_detect_out(det), .system_power_ok_out(sys_ok));
  // Free-running 100 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // Hang guard, generous against a run of about fifteen hundred cycles
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end
  task conclude();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // One APB transfer, request held until pready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    @(posedge clk_in);
    while (pready !== 1'b1) @(posedge clk_in);
    rd = prdata;
    err_s = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wait_oe(input logic v);
    while (oe !== v) @(posedge clk_in);
  endtask : wait_oe
  task toggle_enable();
    enable_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    enable_in <= 1'b1;
    repeat (3) @(posedge clk_in);
  endtask : toggle_enable
  // Mode model: deeper wins, then stop picks deep over active
  function automatic logic [1:0] mode_of(input logic s, input logic d);
    return d ? CRFS_DEEPER : (s ? CRFS_ACTIVE : CRFS_DEEP);
  endfunction : mode_of
  initial begin
    n_fail = 0;
    samples_checked = 0;
    {rst_n_in, enable_in, boot_in, rdy_a, rdy_b, deeper} = 6'h00;
    {uv_below, oc_over, ov_above, psel, penable, pwrite} = 6'h00;
    {stop_n, ov_rel} = 2'h3;
    code_in = '0;
    err = '0;
    paddr = '0;
    pwdata = '0;
    n = $urandom(32'h4c8fdf27);
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    chk("oe_reset", 1, oe);
    chk("gates_reset", 0, {hs, ls});
    apb(1'b0, ADDR_CTRL, 0);
    chk("ctrl_reset", CTRL_RESET, rd);
    apb(1'b0, 8'h10, 0);
    chk("unmapped_err", 1, err_s);
    // Start-up handshake with a random code
    exp_code = $urandom_range(63);
    code_in <= exp_code[5:0];
    enable_in <= 1'b1;
    boot_in <= 1'b1;
    wait_oe(1'b0);
    repeat (10 * P) @(posedge clk_in);
    chk("wait_release", 0, oe);
    rdy_a <= 1'b1;
    rdy_b <= 1'b1;
    wait_oe(1'b1);
    t0 = $time;
    code_in <= ~exp_code[5:0];
    repeat (3) @(posedge clk_in);
    chk("latched_code", exp_code, act_code);
    code_in <= exp_code[5:0];
    wait_oe(1'b0);
    n = int'(($time - t0) / 10);
    chk("pg_delay", 1, n >= (D - 1) * P && n <= D * P + 4);
    chk("system_ok", 1, sys_ok);
    chk("line_data", 0, pg_o);
    apb(1'b0, ADDR_CODE, 0);
    chk("code_reg", exp_code, rd);
    // Duty follows error level, phases not coincident
    e = $urandom_range(P - 1, 1);
    err <= e[6:0];
    repeat (2 * P) @(posedge clk_in);
    n = 0;
    m = 0;
    for (int i = 0; i < 8 * P; i++) begin
      @(posedge clk_in);
      n += hs[0];
      m += (hs[0] != hs[1]);
    end
    chk("duty", 8 * e, n);
    chk("interleave", 1, m > 0);
    // Every mode through the decoder, power-good masked meanwhile
    for (int i = 0; i < 4; i++) begin
      stop_n <= i[1];
      deeper <= i[0] ^ i[1];
      t0 = $time;
      repeat (3) @(posedge clk_in);
      chk("mode", mode_of(i[1], i[0] ^ i[1]), sel);
      chk("mode_mask", 1, oe);
    end
    wait_oe(1'b0);
    n = int'(($time - t0) / 10);
    chk("mask_len", 1, n >= (MASK_PERIODS - 1) * P);
    // Undervoltage just short of the window, then past it
    uv_below <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk("uv_pg_low", 1, oe);
    repeat (30 * P - 3) @(posedge clk_in);
    apb(1'b0, ADDR_STATUS, 0);
    chk("uv_early", 0, rd[ST_UV_BIT]);
    repeat (10 * P) @(posedge clk_in);
    uv_below <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk("uv_gates", 0, {hs, ls});
    chk("uv_pg_held", 1, oe);
    apb(1'b0, ADDR_STATUS, 0);
    chk("uv_trip", 1, rd[ST_UV_BIT]);
    toggle_enable();
    apb(1'b0, ADDR_STATUS, 0);
    chk("uv_clear", 0, rd[ST_UV_BIT]);
    // Overcurrent burst that recovers, then one that trips
    oc_over <= 1'b1;
    repeat (20 * P) @(posedge clk_in);
    oc_over <= 1'b0;
    repeat (24 * P) @(posedge clk_in);
    apb(1'b0, ADDR_COUNT, 0);
    chk("oc_count", (20 > 24) ? 20 - 24 : 0, rd[13:8]);
    apb(1'b0, ADDR_STATUS, 0);
    chk("oc_no_trip", 0, rd[ST_OC_BIT]);
    oc_over <= 1'b1;
    repeat (28 * P) @(posedge clk_in);
    apb(1'b0, ADDR_STATUS, 0);
    chk("oc_early", 0, rd[ST_OC_BIT]);
    repeat (6 * P) @(posedge clk_in);
    oc_over <= 1'b0;
    chk("oc_gates", 0, {hs, ls});
    apb(1'b0, ADDR_STATUS, 0);
    chk("oc_trip", 1, rd[ST_OC_BIT]);
    toggle_enable();
    // Overvoltage crowbar and hysteresis
    ov_rel <= 1'b0;
    ov_above <= 1'b1;
    repeat (2) @(posedge clk_in);
    chk("ov_crowbar", 4'h3, {hs, ls});
    ov_above <= 1'b0;
    repeat (2) @(posedge clk_in);
    chk("ov_hold_low", 4'h3, {hs, ls});
    ov_rel <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk("ov_all_off", 0, {hs, ls});
    ov_rel <= 1'b0;
    ov_above <= 1'b1;
    repeat (2) @(posedge clk_in);
    chk("ov_cycle", 4'h3, {hs, ls});
    ov_above <= 1'b0;
    ov_rel <= 1'b1;
    toggle_enable();
    apb(1'b0, ADDR_STATUS, 0);
    chk("ov_kept", 1, rd[ST_OV_BIT]);
    // Run permit written off and read back
    apb(1'b1, ADDR_CTRL, 0);
    apb(1'b0, ADDR_CTRL, 0);
    chk("ctrl_write", 0, rd);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    apb(1'b0, ADDR_STATUS, 0);
    chk("ov_por", 0, rd[ST_OV_BIT]);
    conclude();
  end
endmodule : crfs_supervisor_test
`default_nettype wire
